// *** rheostat_defs.svh ***
`ifndef RHEOSTAT_DEFS_SVH
`define RHEOSTAT_DEFS_SVH

// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define CMD_W 16
`define DATA_W 10
`define CTRL_W 10
`define FUSE_AW 6

// ----------------------------------------------------------------------------
// Control register bit positions and reset value
// ----------------------------------------------------------------------------
`define CTRL_FPE_BIT 0
`define CTRL_UNLOCK_BIT 1
`define CTRL_CALOFF_BIT 2
`define CTRL_OK_BIT 3
`define CTRL_RESET 4'h0

// ----------------------------------------------------------------------------
// Fuse memory and wiper values
// ----------------------------------------------------------------------------
`define FUSE_NONE 6'h00
`define FUSE_FIRST 6'h01
`define FUSE_LAST 6'h32
`define WIPER_MID 10'h200
`define WIPER_MASK8 10'h3FC
`define WIPER_MASK10 10'h3FF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STORE_TIME_MS 350
`define SYS_PERIOD_NS 8
`define STORE_CYCLES ((`STORE_TIME_MS * 1000000) / `SYS_PERIOD_NS)

`endif

// *** rheostat_pkg.sv ***
package rheostat_pkg;

  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_WRITE      = 4'h1,
    CMD_READ_WIPER = 4'h2,
    CMD_STORE      = 4'h3,
    CMD_SW_RESET   = 4'h4,
    CMD_READ_FUSE  = 4'h5,
    CMD_READ_ADDR  = 4'h6,
    CMD_WRITE_CTRL = 4'h7,
    CMD_READ_CTRL  = 4'h8,
    CMD_SHUTDOWN   = 4'h9
  } cmd_e;

  typedef struct packed {
    logic [1:0] pad;
    cmd_e code;
    logic [9:0] data;
  } cmd_word_s;

  typedef struct packed {
    logic fuseProgramSuccess;
    logic calibrationDisable;
    logic wiperWriteUnlock;
    logic fuseProgramEnable;
  } ctrl_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } store_e;

endpackage : rheostat_pkg

// *** rheostat_command_decoder.sv ***
// What this block does
// RL1: Wiper and fuse changes blocked after power-up.
// RL2: Unlock resets zero; locked wiper ignores writes.
// RL3: Host sets unlock via control write first.
// RL4: No fuse programming while enable bit zero.
// RL5: Code 0 changes nothing, readback still flows.
// RL6: Code 1 loads wiper when unlocked.
// RL7: Code 2 returns wiper next frame.
// RL8: Code 3 stores wiper to next fuse.
// RL9: Code 4 reloads wiper from last fuse.
// RL10: Code 5 returns selected fuse location.
// RL11: Code 6 returns last programmed address.
// RL12: Code 7 writes three control bits.
// RL13: Code 8 returns control register low bits.
// RL14: Code 9 data bit zero sets shutdown.
// RL15: Readback is 16 bits, next frame.
// RL16: Host may unlock both with 0x1C03.
// RL17: Control bits nine to four read zero.
// RL18: Calibration disable one turns calibration off.
// RL19: Success flag set after completed store.
// RL20: Reset wiper is last fuse or midscale.
// RL21: Word: two zeros, code, ten data.
// RL22: Stores start at 0x01, then increment.
// RL23: Command path locked during fuse store.
// RL24: Disabled write or store is ignored.
// RL25: Codes 10 to 15 change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "rheostat_defs.svh"

module rheostat_command_decoder
  import rheostat_pkg::*;
#(
  parameter bit EIGHT_BIT_VARIANT = 1'b0,
  parameter logic [31:0] STORE_CYCLES = `STORE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic powerOnRst,
  input wire logic linkClk,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  output logic cmdReady,
  output logic [15:0] readbackOutput,
  output logic [9:0] wiperSetting,
  output logic shutdown,
  output logic calibrationDisable,
  output logic fuseBusy,
  output logic [9:0] protectionControl
);

  // --------------------------------------------------------------------------
  // Link domain
  // --------------------------------------------------------------------------
  logic linkRstMeta_q;
  logic linkRst_q;
  logic reqTgl_q;
  logic [15:0] cmdHold_q;
  logic ackMeta_q;
  logic ackSync_q;
  logic rdMeta_q;
  logic rdSync_q;
  logic rdSeen_q;
  logic cmdReady_q;
  logic [15:0] readbackOutput_q;
  logic accept;
  // Sys domain signals crossing into the link.
  logic ackTgl_q;
  logic rdTgl_q;
  logic [15:0] rdbk_q;

  assign accept = cmdValid && cmdReady_q;

  always_ff @(posedge linkClk) begin
    linkRstMeta_q <= rst;
    linkRst_q <= linkRstMeta_q;
  end

  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
      rdMeta_q <= 1'b0;
      rdSync_q <= 1'b0;
      rdSeen_q <= 1'b0;
    end else begin
      ackMeta_q <= ackTgl_q;
      ackSync_q <= ackMeta_q;
      rdMeta_q <= rdTgl_q;
      rdSync_q <= rdMeta_q;
      rdSeen_q <= rdSync_q;
    end
  end

  // The held word stays stable until the sys side acknowledges it, so the
  // sys domain may sample it once the request toggle has been synchronised.
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      reqTgl_q <= 1'b0;
      cmdHold_q <= 16'h0000;
    end else if (accept) begin
      reqTgl_q <= ~reqTgl_q;
      cmdHold_q <= cmdWord;
    end
  end

  // RL23 lock during store
  // The sys side withholds its acknowledge until a fuse store has finished,
  // which keeps the command path closed for the whole programming time.
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      cmdReady_q <= 1'b0;
    end else begin
      cmdReady_q <= !accept && (reqTgl_q == ackSync_q);
    end
  end

  // RL15 readback next frame
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      readbackOutput_q <= 16'h0000;
    end else if (rdSync_q != rdSeen_q) begin
      readbackOutput_q <= rdbk_q;
    end
  end

  assign cmdReady = cmdReady_q;
  assign readbackOutput = readbackOutput_q;

  // --------------------------------------------------------------------------
  // Command intake in the sys domain
  // --------------------------------------------------------------------------
  logic reqMeta_q;
  logic reqSync_q;
  logic reqSeen_q;
  logic exec;
  cmd_word_s cmd;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
    end else begin
      reqMeta_q <= reqTgl_q;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSync_q;
    end
  end

  // RL21 word layout
  assign cmd = cmd_word_s'(cmdHold_q);
  assign exec = (reqSync_q != reqSeen_q);

  // --------------------------------------------------------------------------
  // State and decode
  // --------------------------------------------------------------------------
  store_e state_q;
  logic [31:0] timer_q;
  ctrl_s ctrl_q;
  logic [9:0] wiper_q;
  logic shutdown_q;
  logic [5:0] ptr_q;
  logic [9:0] fuseMem [0:63];
  logic [9:0] reloadVal;
  logic [9:0] fuseRead;
  logic [9:0] wiperMask;
  logic doWrite;
  logic doStore;
  logic doSwReset;
  logic storeDone;

  assign wiperMask = EIGHT_BIT_VARIANT ? `WIPER_MASK8 : `WIPER_MASK10;
  // RL20 reset value
  assign reloadVal = (ptr_q == `FUSE_NONE) ? `WIPER_MID : fuseMem[ptr_q];
  assign fuseRead = (cmd.data[5:0] != `FUSE_NONE && cmd.data[5:0] <= ptr_q) ? fuseMem[cmd.data[5:0]] : 10'h000;

  // RL1 gated by enables
  // RL24 disabled commands ignored
  assign doWrite = exec && cmd.code == CMD_WRITE && ctrl_q.wiperWriteUnlock;
  assign doStore = exec && cmd.code == CMD_STORE && ctrl_q.fuseProgramEnable && ptr_q < `FUSE_LAST;
  assign doSwReset = exec && cmd.code == CMD_SW_RESET;
  assign storeDone = state_q == ST_PROG && timer_q == 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Fuse store sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (doStore) begin
            state_q <= ST_PROG;
            timer_q <= STORE_CYCLES - 32'h0000_0001;
          end
        end
        ST_PROG: begin
          if (timer_q == 32'h0000_0000) begin
            state_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // RL22 store pointer
  // The pointer models one-time fuses, so only a power-on clears it; the
  // reset pin must leave the programmed history in place.
  always_ff @(posedge sys_clk) begin
    if (powerOnRst) begin
      ptr_q <= `FUSE_NONE;
    end else if (doStore) begin
      ptr_q <= ptr_q + `FUSE_FIRST;
    end
  end

  // RL8 store wiper
  always_ff @(posedge sys_clk) begin
    if (doStore && !powerOnRst) begin
      fuseMem[ptr_q + `FUSE_FIRST] <= wiper_q;
    end
  end

  // --------------------------------------------------------------------------
  // Control register, wiper and shutdown
  // --------------------------------------------------------------------------
  // RL4 enable resets zero
  // RL19 success flag
  // RL12 control write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= ctrl_s'(`CTRL_RESET);
    end else begin
      if (exec && cmd.code == CMD_WRITE_CTRL) begin
        ctrl_q.fuseProgramEnable <= cmd.data[`CTRL_FPE_BIT];
        ctrl_q.wiperWriteUnlock <= cmd.data[`CTRL_UNLOCK_BIT];
        ctrl_q.calibrationDisable <= cmd.data[`CTRL_CALOFF_BIT];
      end
      if (storeDone) begin
        ctrl_q.fuseProgramSuccess <= 1'b1;
      end else if (doStore) begin
        ctrl_q.fuseProgramSuccess <= 1'b0;
      end
    end
  end

  // RL2 locked wiper
  // RL9 software reset reload
  // RL6 wiper write
  always_ff @(posedge sys_clk) begin
    if (rst || doSwReset) begin
      wiper_q <= reloadVal & wiperMask;
    end else if (doWrite) begin
      wiper_q <= cmd.data & wiperMask;
    end
  end

  // RL14 shutdown control
  always_ff @(posedge sys_clk) begin
    if (rst || doSwReset) begin
      shutdown_q <= 1'b0;
    end else if (exec && cmd.code == CMD_SHUTDOWN) begin
      shutdown_q <= cmd.data[0];
    end
  end

  // --------------------------------------------------------------------------
  // Readback and acknowledge
  // --------------------------------------------------------------------------
  // RL5 echo pending readback
  // RL10 fuse readback
  // RL11 address readback
  // RL13 control readback
  // RL7 wiper readback
  // RL25 reserved codes echo only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdbk_q <= 16'h0000;
      rdTgl_q <= 1'b0;
    end else if (exec) begin
      rdTgl_q <= ~rdTgl_q;
      case (cmd.code)
        CMD_READ_WIPER: rdbk_q <= {6'h00, wiper_q};
        CMD_READ_FUSE: rdbk_q <= {6'h00, fuseRead};
        CMD_READ_ADDR: rdbk_q <= {10'h000, ptr_q};
        CMD_READ_CTRL: rdbk_q <= {12'h000, ctrl_q};
        default: rdbk_q <= cmdHold_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ackTgl_q <= 1'b0;
    end else if ((exec && !doStore) || storeDone) begin
      ackTgl_q <= ~ackTgl_q;
    end
  end

  assign wiperSetting = wiper_q;
  assign shutdown = shutdown_q;
  // RL18 calibration off
  assign calibrationDisable = ctrl_q.calibrationDisable;
  assign fuseBusy = state_q;
  // RL17 upper bits zero
  assign protectionControl = {6'h00, ctrl_q};

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_locked_write: assert property ( // RL2
    exec && cmd.code == CMD_WRITE && !ctrl_q.wiperWriteUnlock |=> $stable(wiper_q))
    else $error("wiper changed while locked");
  chk_unlocked_write: assert property ( // RL6
    doWrite |=> wiper_q == ($past(cmd.data) & wiperMask))
    else $error("wiper write not loaded");
  chk_store_gate: assert property ( // RL4
    exec && cmd.code == CMD_STORE && !ctrl_q.fuseProgramEnable |=> $stable(ptr_q) && state_q == ST_IDLE)
    else $error("store ran while disabled");
  chk_store_ptr: assert property ( // RL22
    doStore |=> ptr_q == $past(ptr_q) + `FUSE_FIRST && state_q == ST_PROG)
    else $error("store pointer not advanced");
  chk_success_flag: assert property ( // RL19
    storeDone |=> ctrl_q.fuseProgramSuccess && state_q == ST_IDLE)
    else $error("success flag not set");
  chk_sw_reset: assert property ( // RL9
    doSwReset |=> wiper_q == ($past(reloadVal) & wiperMask) && !shutdown_q)
    else $error("software reset reload wrong");
  chk_ctrl_write: assert property ( // RL12
    exec && cmd.code == CMD_WRITE_CTRL && !storeDone |=> ctrl_q[2:0] == $past(cmd.data[2:0]))
    else $error("control write wrong");
  chk_shutdown_cmd: assert property ( // RL14
    exec && cmd.code == CMD_SHUTDOWN |=> shutdown_q == $past(cmd.data[0]))
    else $error("shutdown not followed");
  chk_rdbk_wiper: assert property ( // RL7
    exec && cmd.code == CMD_READ_WIPER |=> rdbk_q == {6'h00, $past(wiper_q)})
    else $error("wiper readback wrong");
  chk_store_lock: assert property ( // RL23
    state_q == ST_PROG && !storeDone |=> $stable(ackTgl_q))
    else $error("acknowledge during store");
  chk_nop_reserved: assert property ( // RL25
    exec && (cmd.code == CMD_NOP || cmd.code > CMD_SHUTDOWN) && state_q == ST_IDLE
      |=> $stable(wiper_q) && $stable(ctrl_q) && $stable(ptr_q) && $stable(shutdown_q))
    else $error("no-op changed state");

  cov_store_done: cover property (storeDone);
  cov_unlocked_write: cover property (doWrite);
  cov_fuse_read: cover property (exec && cmd.code == CMD_READ_FUSE && ptr_q != `FUSE_NONE);
  cov_link_accept: cover property (@(posedge linkClk) disable iff (linkRst_q) accept);

endmodule : rheostat_command_decoder
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input wire logic linkClk,
  input wire logic cmdReady,
  output logic cmdValid,
  output logic [15:0] cmdWord
);

  initial begin
    cmdValid = 1'b0;
    cmdWord = 16'hFFFF;
  end

  // ---------------------------------------------------------------------------
  // Command request
  // ---------------------------------------------------------------------------
  // whole word held
  task automatic send(input logic [15:0] w, input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge linkClk);
    @(posedge linkClk);
    cmdWord <= w;
    cmdValid <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge linkClk);
      if (cmdReady === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    cmdValid <= 1'b0;
    // A released word shows the inverse so that no stale value passes for a new one.
    cmdWord <= ~w;
  endtask : send

endmodule : host_model

`default_nettype wire

// *** rheostat_command_decoder_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module rheostat_command_decoder_bench
  import rheostat_pkg::*;
;
  logic sys_clk, linkClk, rst, powerOnRst, cmdValid, cmdReady, shutdown, calibrationDisable, fuseBusy;
  logic [15:0] cmdWord, readbackOutput, e;
  logic [9:0] wiperSetting, protectionControl, wr, rnd;
  logic [15:0] expQ[$];
  logic readyPrev, pending;
  int n_errors, num_checks, seed, i;

  // ---------------------------------------------------------------------------
  // Clocks and instances
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // The link clock is offset so that its edges walk across the system clock.
  initial begin
    linkClk = 1'b0;
    #3;
    forever begin
      #62 linkClk = 1'b1;
      #63 linkClk = 1'b0;
    end
  end

  rheostat_command_decoder #(.STORE_CYCLES(32'h0000_0014)) dut (
    .sys_clk(sys_clk), .rst(rst), .powerOnRst(powerOnRst), .linkClk(linkClk),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .readbackOutput(readbackOutput),
    .wiperSetting(wiperSetting), .shutdown(shutdown), .calibrationDisable(calibrationDisable),
    .fuseBusy(fuseBusy), .protectionControl(protectionControl)
  );

  host_model host (.linkClk(linkClk), .cmdReady(cmdReady), .cmdValid(cmdValid), .cmdWord(cmdWord));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic timed_out(input string what);
    n_errors++;
    $display("Error %s expected done seen timeout", what);
    wrap_up();
  endtask : timed_out

  function automatic logic [15:0] word(input logic [3:0] c, input logic [9:0] d);
    return {2'b00, c, d};
  endfunction : word

  task automatic issue(input logic [3:0] c, input logic [9:0] d, input logic [15:0] rb);
    bit ok;
    expQ.push_back(rb);
    host.send(word(c, d), $unsigned($random(seed)) % 4, ok);
    if (!ok) timed_out("command intake");
  endtask : issue

  task automatic settle();
    int n;
    for (n = 0; n < 64 && expQ.size() > 0; n++) @(negedge linkClk);
    if (expQ.size() > 0) timed_out("readback");
  endtask : settle

  task automatic cmd(input logic [3:0] c, input logic [9:0] d, input logic [15:0] rb);
    issue(c, d, rb);
    settle();
  endtask : cmd

  task automatic do_reset(input logic pwr);
    @(posedge sys_clk);
    rst <= 1'b1;
    powerOnRst <= pwr;
    repeat (3) @(posedge linkClk);
    @(posedge sys_clk);
    rst <= 1'b0;
    powerOnRst <= 1'b0;
  endtask : do_reset

  // ---------------------------------------------------------------------------
  // Readback monitor: a new word is due when intake reopens after a taken word.
  // ---------------------------------------------------------------------------
  // Intake also opens after every reset, so a rise of ready only counts as a
  // readback once a word has really been taken at the link.
  always @(negedge linkClk) begin
    if (cmdReady === 1'b1 && readyPrev === 1'b0 && pending && expQ.size() > 0) begin
      e = expQ.pop_front();
      check("readback", e, readbackOutput);
      pending = 1'b0;
    end
    if (cmdReady === 1'b1 && cmdValid === 1'b1) begin
      pending = 1'b1;
    end
    readyPrev = cmdReady;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h702b_dfb1;
    rst = 1'b1;
    powerOnRst = 1'b1;
    readyPrev = 1'b0;
    pending = 1'b0;
    do_reset(1'b1);
    cmd(CMD_WRITE, 10'h155, word(CMD_WRITE, 10'h155));
    check("wiper", 16'h0200, {6'b0, wiperSetting});
    cmd(CMD_STORE, 10'h000, 16'h0C00);
    cmd(CMD_READ_ADDR, 10'h000, 16'h0000);
    cmd(CMD_WRITE_CTRL, 10'h003, 16'h1C03);
    cmd(CMD_READ_CTRL, 10'h000, 16'h0003);
    wr = 10'($random(seed));
    cmd(CMD_WRITE, wr, word(CMD_WRITE, wr));
    cmd(CMD_READ_WIPER, 10'h000, {6'b0, wr});
    issue(CMD_STORE, 10'h000, 16'h0C00);
    for (i = 0; i < 200 && fuseBusy !== 1'b1; i++) @(negedge sys_clk);
    if (fuseBusy !== 1'b1) timed_out("store start");
    check("intake during store", 16'h0000, {15'b0, cmdReady});
    settle();
    check("busy", 16'h0000, {15'b0, fuseBusy});
    cmd(CMD_READ_ADDR, 10'h000, 16'h0001);
    cmd(CMD_READ_FUSE, 10'h001, {6'b0, wr});
    cmd(CMD_READ_FUSE, 10'h002, 16'h0000);
    cmd(CMD_READ_CTRL, 10'h000, 16'h000B);
    cmd(CMD_WRITE, 10'h3FF, word(CMD_WRITE, 10'h3FF));
    cmd(CMD_SW_RESET, 10'h000, 16'h1000);
    check("wiper", {6'b0, wr}, {6'b0, wiperSetting});
    cmd(CMD_WRITE_CTRL, 10'h006, 16'h1C06);
    check("calibration", 16'h0001, {15'b0, calibrationDisable});
    check("control", 16'h000E, {6'b0, protectionControl});
    cmd(CMD_STORE, 10'h000, 16'h0C00);
    cmd(CMD_READ_ADDR, 10'h000, 16'h0001);
    cmd(CMD_SHUTDOWN, 10'h001, 16'h2401);
    check("shutdown", 16'h0001, {15'b0, shutdown});
    for (i = 10; i < 16; i++) begin
      rnd = 10'($random(seed));
      cmd(4'(i), rnd, word(4'(i), rnd));
    end
    cmd(CMD_NOP, 10'h2AA, 16'h02AA);
    check("wiper", {6'b0, wr}, {6'b0, wiperSetting});
    check("shutdown", 16'h0001, {15'b0, shutdown});
    cmd(CMD_SHUTDOWN, 10'h000, 16'h2400);
    check("shutdown", 16'h0000, {15'b0, shutdown});
    do_reset(1'b0);
    @(negedge sys_clk);
    check("wiper", {6'b0, wr}, {6'b0, wiperSetting});
    check("control", 16'h0000, {6'b0, protectionControl});
    cmd(CMD_WRITE, 10'h000, 16'h0400);
    check("wiper", {6'b0, wr}, {6'b0, wiperSetting});
    wrap_up();
  end

endmodule : rheostat_command_decoder_bench

`default_nettype wire
